// ### pmd_finder_model.sv
// Upstream finder pair model, normal and split wire sets
`timescale 1ns/1ps
module pmd_finder_model (
  // Clock, reset and controls
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic skew_i,
  input wire logic fault_i,
  input wire logic split_i,
  // Finder pins
  output pmd_pkg::pmd_finder_type norm_a_o,
  output pmd_pkg::pmd_finder_type norm_b_o,
  output pmd_pkg::pmd_finder_type split_a_o,
  output pmd_pkg::pmd_finder_type split_b_o
);
  logic [2:0] tick;
  logic [7:0] seq;
  logic beam;

  // New slice every 5 cycles; frozen pins let the bench predict links
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick <= 3'h0;
      seq <= 8'h00;
    end
    else if (run_i)
    begin
      tick <= (tick == 3'h4) ? 3'h0 : tick + 3'h1;
      if (tick == 3'h0)
        seq <= seq + 8'h01;
    end
  end

  assign beam = (seq[3:0] == 4'h0);
  assign norm_a_o = {seq, 4'hA, beam, seq[1:0] == 2'h0, 1'b1, fault_i};
  assign norm_b_o = {4'h5, seq, beam ^ skew_i, seq[1:0] == 2'h0, 1'b1, 1'b0};
  assign split_a_o = {split_i ? 12'h801 : 12'h000, 4'h0};
  assign split_b_o = {split_i ? 12'h030 : 12'h000, 4'h0};
endmodule

// ### pmd_merge_dup.sv
// Pixel merge, duplication, pipeline, level-2 buffers and diagnostic RAM
//
// Notes on behaviour
// - OR markers of both finders, pixels kept apart
// - Each slice load two identical 28-bit registers
// - Each copy drives its own link pins
// - Fault on marker mismatch or finder fault
// - Store both finders in 30-bit level-1 pipeline
// - Software sets 8-bit pipeline depth
// - Two link enables; low holds outputs
// - Select plus address; direction picks read/write
// - Write strobe commits data to register
// - Read returns addressed register without strobe
// - Fixed latency compensation inside this block
// - Four inputs: two pipelines, normal OR split
// - Receiver mode captures next 256 slices
// - Arm on rising cycle bit, then trigger
// - Trigger slice skipped, next at location zero
// - Capture writes stop after 256 slices
// - Receiver mode still merges and duplicates
// - Driver mode plays RAM words to outputs
// - Driver address wraps while cycle bit set
// - Pipeline write counter wraps at depth minus compensation slices
// - Level-1 accept stores four slices in buffer
`timescale 1ns/1ps

module pmd_merge_dup #(
  parameter int FOUR_INPUT = 1,
  parameter int DEPTH_W = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Finder inputs, asynchronous pins
  input wire pmd_pkg::pmd_finder_type fnd_norm_a_i,
  input wire pmd_pkg::pmd_finder_type fnd_norm_b_i,
  input wire pmd_pkg::pmd_finder_type fnd_split_a_i,
  input wire pmd_pkg::pmd_finder_type fnd_split_b_i,
  // Level-1 trigger, asynchronous pins
  input wire logic l1_accept_i,
  input wire logic [1:0] l1_addr_i,
  // Link transmitter pins
  output pmd_pkg::pmd_link_type link0_o,
  output pmd_pkg::pmd_link_type link1_o
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  initial
  begin
    if (DEPTH_W != 8)
      $error("DEPTH_W must be 8 to address the 256-slice pipeline");
    if (FOUR_INPUT != 0 && FOUR_INPUT != 1)
      $error("FOUR_INPUT must be 0 or 1");
  end

  typedef enum logic [4:0] {
    PMD_L2_IDLE = 5'h01,
    PMD_L2_ST0 = 5'h02,
    PMD_L2_ST1 = 5'h04,
    PMD_L2_ST2 = 5'h08,
    PMD_L2_ST3 = 5'h10
  } pmd_l2_state_type;

  typedef enum logic [3:0] {
    PMD_DG_IDLE = 4'h1,
    PMD_DG_ARMED = 4'h2,
    PMD_DG_FILL = 4'h4,
    PMD_DG_FULL = 4'h8
  } pmd_dg_state_type;

  function automatic pmd_pkg::pmd_slice_type merge(input pmd_pkg::pmd_finder_type a,
                                                   input pmd_pkg::pmd_finder_type b);
    pmd_pkg::pmd_slice_type s;
    s.merged.pix_a = a.pix;
    s.merged.pix_b = b.pix;
    s.merged.beam0 = a.beam0 | b.beam0;
    s.merged.word0 = a.word0 | b.word0;
    s.merged.start_link = a.start_link | b.start_link;
    s.merged.fault = (a.beam0 ^ b.beam0) | (a.word0 ^ b.word0)
                     | (a.start_link ^ b.start_link) | a.fault | b.fault;
    s.fault_a = a.fault;
    s.fault_b = b.fault;
    return s;
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  pmd_pkg::pmd_finder_type fnd_meta [0:3];
  pmd_pkg::pmd_finder_type fnd_sync [0:3];
  logic [2:0] l1_meta;
  logic [2:0] l1_sync;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
      begin
        fnd_meta[i] <= '0;
        fnd_sync[i] <= '0;
      end
      l1_meta <= 3'h0;
      l1_sync <= 3'h0;
    end
    else
    begin
      fnd_meta[0] <= fnd_norm_a_i;
      fnd_meta[1] <= fnd_norm_b_i;
      fnd_meta[2] <= (FOUR_INPUT != 0) ? fnd_split_a_i : '0;
      fnd_meta[3] <= (FOUR_INPUT != 0) ? fnd_split_b_i : '0;
      fnd_sync <= fnd_meta;
      l1_meta <= {l1_accept_i, l1_addr_i};
      l1_sync <= l1_meta;
    end
  end

  // ****************************************************************
  // Slice enable divider
  // ****************************************************************
  localparam logic [3:0] SLICE_LAST = 4'(pmd_pkg::SLICE_CYCLES - 1);
  logic [3:0] slice_cnt;
  logic slice_en;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      slice_cnt <= 4'h0;
      slice_en <= 1'b0;
    end
    else
    begin
      slice_en <= (slice_cnt == SLICE_LAST);
      slice_cnt <= (slice_cnt == SLICE_LAST) ? 4'h0 : slice_cnt + 4'h1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] depth;
  logic [1:0] link_en;
  logic diag_cycle;
  pmd_pkg::pmd_mode_type mode;
  logic [4:0] l2_sel;
  logic bus_write;
  logic bus_setup;
  logic [31:0] ram_q;
  logic rd_stage;
  logic [11:0] rd_addr;

  // Strobe: access phase with our ready up
  assign bus_write = psel_i & penable_i & pready_o & pwrite_i;
  assign bus_setup = psel_i & ~penable_i;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      depth <= pmd_pkg::DEPTH_RST;
      link_en <= pmd_pkg::LINK_EN_RST;
      diag_cycle <= 1'b0;
      mode <= pmd_pkg::PMD_MODE_NORMAL;
      l2_sel <= 5'h00;
    end
    else if (bus_write)
    begin
      case (paddr_i)
        pmd_pkg::REG_CTRL:
        begin
          depth <= pwdata_i[pmd_pkg::CTRL_DEPTH_LSB +: 8];
          link_en <= pwdata_i[pmd_pkg::CTRL_LINK_EN_LSB +: 2];
        end
        pmd_pkg::REG_DIAG:
        begin
          diag_cycle <= pwdata_i[pmd_pkg::DIAG_CYCLE_BIT];
          mode <= pmd_pkg::pmd_mode_type'(pwdata_i[pmd_pkg::DIAG_MODE_LSB +: 2]);
        end
        pmd_pkg::REG_L2_SEL:
          l2_sel <= pwdata_i[4:0];
        default:
          l2_sel <= l2_sel;
      endcase
    end
  end

  // ****************************************************************
  // Merge and duplicate
  // ****************************************************************
  pmd_pkg::pmd_finder_type comb_a;
  pmd_pkg::pmd_finder_type comb_b;
  pmd_pkg::pmd_slice_type slice_norm;
  pmd_pkg::pmd_slice_type slice_split;
  pmd_pkg::pmd_slice_type slice_out;
  logic drive_on;
  logic [31:0] drv_word;
  pmd_pkg::pmd_link_type out_word;

  // Split-wire finders fold into their normal partner
  assign comb_a = fnd_sync[0] | fnd_sync[2];
  assign comb_b = fnd_sync[1] | fnd_sync[3];
  assign slice_norm = merge(fnd_sync[0], fnd_sync[1]);
  assign slice_split = merge(fnd_sync[2], fnd_sync[3]);
  assign slice_out = merge(comb_a, comb_b);
  assign drive_on = diag_cycle & (mode == pmd_pkg::PMD_MODE_DRIVE);
  assign out_word = drive_on ? pmd_pkg::pmd_link_type'(drv_word[27:0])
                             : slice_out.merged;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link0_o <= '0;
      link1_o <= '0;
    end
    else if (slice_en)
    begin
      if (link_en[0])
        link0_o <= out_word;
      if (link_en[1])
        link1_o <= out_word;
    end
  end

  // ****************************************************************
  // Level-1 pipeline
  // ****************************************************************
  pmd_pkg::pmd_slice_type pipe_mem [0:1][0:255];
  pmd_pkg::pmd_slice_type pipe_out [0:1];
  logic [7:0] wr_addr;
  logic [7:0] wrap_at;
  logic pipe_on;

  // Finder data arrives late, so the loop is shortened to line slices up
  assign wrap_at = (depth > pmd_pkg::PIPE_COMP_SLICES) ? depth - pmd_pkg::PIPE_COMP_SLICES
                                                        : 8'h00;
  // Capture RAM stands in for the pipeline in receiver mode
  assign pipe_on = (mode != pmd_pkg::PMD_MODE_RECEIVE);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      wr_addr <= 8'h00;
    else if (slice_en)
      wr_addr <= (wr_addr == wrap_at) ? 8'h00 : wr_addr + 8'h01;
  end

  // Read then overwrite the same slot: the oldest slice leaves first
  always_ff @(posedge core_clk_i)
  begin
    if (slice_en && pipe_on)
    begin
      pipe_out[0] <= pipe_mem[0][wr_addr];
      pipe_mem[0][wr_addr] <= slice_norm;
      pipe_out[1] <= pipe_mem[1][wr_addr];
      pipe_mem[1][wr_addr] <= slice_split;
    end
  end

  // ****************************************************************
  // Level-2 buffers
  // ****************************************************************
  pmd_pkg::pmd_slice_type l2_buf [0:1][0:3][0:3];
  pmd_l2_state_type l2_state;
  logic [1:0] l2_target;
  logic [1:0] l2_slot;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      l2_state <= PMD_L2_IDLE;
      l2_target <= 2'h0;
    end
    else if (slice_en && pipe_on)
    begin
      case (l2_state)
        PMD_L2_IDLE:
          if (l1_sync[2])
          begin
            l2_state <= PMD_L2_ST0;
            l2_target <= l1_sync[1:0];
          end
        PMD_L2_ST0:
          l2_state <= PMD_L2_ST1;
        PMD_L2_ST1:
          l2_state <= PMD_L2_ST2;
        PMD_L2_ST2:
          l2_state <= PMD_L2_ST3;
        PMD_L2_ST3:
          if (l1_sync[2])
          begin
            l2_state <= PMD_L2_ST0;
            l2_target <= l1_sync[1:0];
          end
          else
            l2_state <= PMD_L2_IDLE;
        default:
          l2_state <= PMD_L2_IDLE;
      endcase
    end
  end

  always_comb
  begin
    case (l2_state)
      PMD_L2_ST1: l2_slot = 2'h1;
      PMD_L2_ST2: l2_slot = 2'h2;
      PMD_L2_ST3: l2_slot = 2'h3;
      default: l2_slot = 2'h0;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (slice_en && pipe_on && l2_state != PMD_L2_IDLE)
    begin
      l2_buf[0][l2_target][l2_slot] <= pipe_out[0];
      l2_buf[1][l2_target][l2_slot] <= pipe_out[1];
    end
  end

  // ****************************************************************
  // Diagnostic capture and playback
  // ****************************************************************
  logic [31:0] diag_ram [0:pmd_pkg::DIAG_WORDS-1];
  pmd_dg_state_type dg_state;
  logic cycle_prev;
  logic [8:0] cap_cnt;
  logic [7:0] drv_addr;
  logic trig;
  logic cap_we;

  assign trig = (comb_a.beam0 & comb_a.start_link) | (comb_b.beam0 & comb_b.start_link);
  assign cap_we = slice_en && dg_state == PMD_DG_FILL && cap_cnt != pmd_pkg::CAP_SLICES;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dg_state <= PMD_DG_IDLE;
      cycle_prev <= 1'b0;
      cap_cnt <= 9'h000;
    end
    else
    begin
      cycle_prev <= diag_cycle;
      if (!diag_cycle || mode != pmd_pkg::PMD_MODE_RECEIVE)
        dg_state <= PMD_DG_IDLE;
      else
      begin
        case (dg_state)
          PMD_DG_IDLE:
            if (!cycle_prev)
              dg_state <= PMD_DG_ARMED;
          PMD_DG_ARMED:
            if (slice_en && trig)
            begin
              dg_state <= PMD_DG_FILL;
              cap_cnt <= 9'h000;
            end
          PMD_DG_FILL:
            if (cap_we)
            begin
              cap_cnt <= cap_cnt + 9'h001;
              if (cap_cnt == pmd_pkg::CAP_SLICES - 9'h001)
                dg_state <= PMD_DG_FULL;
            end
          PMD_DG_FULL:
            dg_state <= PMD_DG_FULL;
          default:
            dg_state <= PMD_DG_IDLE;
        endcase
      end
    end
  end

  // Cleared word keeps the first played slice free of unknowns
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      drv_addr <= 8'h00;
      drv_word <= 32'h0000_0000;
    end
    else if (!drive_on)
      drv_addr <= 8'h00;
    else if (slice_en)
    begin
      drv_addr <= drv_addr + 8'h01;
      drv_word <= diag_ram[drv_addr];
    end
  end

  // Capture wins over a bus write landing in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (cap_we)
      diag_ram[cap_cnt[7:0]] <= {2'h0, slice_out};
    else if (bus_write && paddr_i[11:10] == pmd_pkg::RAM_WINDOW)
      diag_ram[paddr_i[9:2]] <= pwdata_i;
    if (bus_setup)
      ram_q <= diag_ram[paddr_i[9:2]];
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  logic [31:0] rd_mux;
  logic rd_hit;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (rd_addr[11:10] == pmd_pkg::RAM_WINDOW)
      rd_mux = ram_q;
    else
    begin
      case (rd_addr)
        pmd_pkg::REG_CTRL:
        begin
          rd_mux[pmd_pkg::CTRL_DEPTH_LSB +: 8] = depth;
          rd_mux[pmd_pkg::CTRL_LINK_EN_LSB +: 2] = link_en;
        end
        pmd_pkg::REG_DIAG:
        begin
          rd_mux[pmd_pkg::DIAG_CYCLE_BIT] = diag_cycle;
          rd_mux[pmd_pkg::DIAG_MODE_LSB +: 2] = mode;
        end
        pmd_pkg::REG_STATUS:
        begin
          rd_mux[8:0] = cap_cnt;
          rd_mux[pmd_pkg::STAT_STATE_LSB +: 4] = dg_state;
          rd_mux[pmd_pkg::STAT_DRV_ADDR_LSB +: 8] = drv_addr;
        end
        pmd_pkg::REG_L2_SEL:
          rd_mux[4:0] = l2_sel;
        pmd_pkg::REG_L2_DATA:
          rd_mux[29:0] = l2_buf[l2_sel[4]][l2_sel[3:2]][l2_sel[1:0]];
        default:
          rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_stage <= 1'b0;
      rd_addr <= 12'h000;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      rd_stage <= bus_setup;
      if (bus_setup)
        rd_addr <= paddr_i;
      if (rd_stage)
      begin
        // Read data holds across writes until the next read answer
        if (!pwrite_i)
          prdata_o <= rd_mux;
        pslverr_o <= ~rd_hit;
        pready_o <= 1'b1;
      end
      else if (pready_o && penable_i)
      begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

endmodule

// ### pmd_merge_dup_sva.sv
// Checker of bus timing and link output behaviour
`timescale 1ns/1ps
module pmd_merge_dup_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Links
  input wire pmd_pkg::pmd_link_type link0_o,
  input wire pmd_pkg::pmd_link_type link1_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ********
  // Bus
  // ********
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_answer;
    !pready_o ##1 pready_o;
  endsequence

  a_ready_timing: assert property (s_setup |=> s_answer)
    else $error("ready not two cycles after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  a_err_zero_data: assert property (pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0))
    else $error("error without ready or with data");
  a_rdata_hold: assert property ($changed(prdata_o) |-> pready_o && !pwrite_i)
    else $error("read data moved outside a read answer");

  // ********
  // Links
  // ********
  a_link0_slice: assert property ($changed(link0_o) |=> $stable(link0_o)[*4])
    else $error("link0 changed inside a slice");
  a_link1_slice: assert property ($changed(link1_o) |=> $stable(link1_o)[*4])
    else $error("link1 changed inside a slice");
  a_links_equal: assert property ($changed(link0_o) && $changed(link1_o) |-> link0_o == link1_o)
    else $error("link copies differ");
  a_reset_links: assert property ($fell(rst_i) |-> link0_o == '0 && link1_o == '0)
    else $error("links not clear after reset");
endmodule

bind pmd_merge_dup pmd_merge_dup_sva chk_u (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .link0_o(link0_o),
  .link1_o(link1_o)
);

// ### pmd_merge_dup_tb.sv
// Self-checking bench of the pixel merge and duplication block
`timescale 1ns/1ps
module pmd_merge_dup_tb;
  logic core_clk_i;
  logic rst_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic l1_accept_i;
  logic [1:0] l1_addr_i;
  pmd_pkg::pmd_finder_type fa, fb, sa, sb;
  pmd_pkg::pmd_link_type link0_o, link1_o;
  logic run, skew, flt, split, err;
  logic [31:0] rd, r0, r1;
  int mismatches, cmp_count, cycles;

  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  pmd_finder_model fm_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .run_i(run),
    .skew_i(skew), .fault_i(flt), .split_i(split), .norm_a_o(fa), .norm_b_o(fb),
    .split_a_o(sa), .split_b_o(sb));

  pmd_merge_dup dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .fnd_norm_a_i(fa), .fnd_norm_b_i(fb), .fnd_split_a_i(sa), .fnd_split_b_i(sb),
    .l1_accept_i(l1_accept_i), .l1_addr_i(l1_addr_i), .link0_o(link0_o),
    .link1_o(link1_o));

  task automatic close_out();
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  // Request stands until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk(n < 20, "no ready");
  endtask

  task automatic step(input int n);
    run <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    run <= 1'b0;
    repeat (20) @(posedge core_clk_i);
  endtask

  function automatic pmd_pkg::pmd_link_type mrg(input pmd_pkg::pmd_finder_type a0, b0, a1, b1);
    pmd_pkg::pmd_finder_type a;
    pmd_pkg::pmd_finder_type b;
    a = a0 | a1;
    b = b0 | b1;
    mrg = {a.fault | b.fault | (a.beam0 ^ b.beam0) | (a.word0 ^ b.word0)
      | (a.start_link ^ b.start_link), a.start_link | b.start_link,
      a.word0 | b.word0, a.beam0 | b.beam0, b.pix, a.pix};
  endfunction

  task automatic t_regs();
    apb(1'b0, pmd_pkg::REG_CTRL, 32'h0);
    chk(rd === {22'h0, pmd_pkg::LINK_EN_RST, pmd_pkg::DEPTH_RST}, "ctrl reset");
    apb(1'b1, pmd_pkg::REG_STATUS, 32'hFFFFFFFF);
    apb(1'b0, pmd_pkg::REG_STATUS, 32'h0);
    chk(rd === 32'h00001000, "status idle");
    apb(1'b1, pmd_pkg::REG_CTRL, 32'h00000304);
    apb(1'b0, pmd_pkg::REG_CTRL, 32'h0);
    chk(rd === 32'h00000304 && err === 1'b0, "ctrl readback");
    apb(1'b0, 12'h020, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped");
  endtask

  task automatic t_merge();
    for (int i = 0; i < 4; i++)
    begin
      skew <= i[0];
      flt <= i[1];
      split <= i[0] ^ i[1];
      step(7 * i + 9);
      chk(link0_o === mrg(fa, fb, sa, sb), "merged word");
      chk(link1_o === link0_o, "copies");
    end
  endtask

  task automatic t_hold();
    pmd_pkg::pmd_link_type h;
    apb(1'b1, pmd_pkg::REG_CTRL, 32'h00000104);
    h = link1_o;
    step(13);
    chk(link1_o === h && link0_o === mrg(fa, fb, sa, sb), "link hold");
    apb(1'b1, pmd_pkg::REG_CTRL, 32'h00000304);
  endtask

  task automatic t_l2();
    split <= 1'b1;
    step(12);
    repeat (40) @(posedge core_clk_i);
    l1_addr_i <= 2'h2;
    l1_accept_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    l1_accept_i <= 1'b0;
    repeat (60) @(posedge core_clk_i);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, pmd_pkg::REG_L2_SEL, {27'h0, k[2], 2'h2, k[1:0]});
      apb(1'b0, pmd_pkg::REG_L2_DATA, 32'h0);
      chk(rd === (k[2] ? {2'h0, sb.fault, sa.fault, mrg(sa, sb, '0, '0)}
        : {2'h0, fb.fault, fa.fault, mrg(fa, fb, '0, '0)}), "level-2 slice");
    end
  endtask

  task automatic t_recv();
    int n;
    split <= 1'b0;
    skew <= 1'b0;
    flt <= 1'b0;
    run <= 1'b1;
    apb(1'b1, pmd_pkg::REG_DIAG, 32'h2);
    apb(1'b1, pmd_pkg::REG_DIAG, 32'h3);
    n = 0;
    do
    begin
      apb(1'b0, pmd_pkg::REG_STATUS, 32'h0);
      n++;
    end
    while (rd[15] !== 1'b1 && n < 600);
    chk(rd[15:12] === 4'h8 && rd[8:0] === pmd_pkg::CAP_SLICES, "capture full");
    step(1);
    chk(link0_o === mrg(fa, fb, sa, sb), "merge in capture");
    apb(1'b1, pmd_pkg::REG_DIAG, 32'h2);
    apb(1'b0, 12'h400, 32'h0);
    r0 = rd;
    apb(1'b0, 12'h404, 32'h0);
    r1 = rd;
    apb(1'b0, 12'h7FC, 32'h0);
    chk(r0[7:4] === 4'h1 && r0[31:30] === 2'h0, "first slot");
    chk(r1[11:4] === r0[11:4] + 8'h01, "next slot");
    chk(rd[11:4] === r0[11:4] + 8'hFF, "last slot");
  endtask

  task automatic t_drive();
    logic [7:0] b;
    pmd_pkg::pmd_link_type p;
    int n;
    apb(1'b1, pmd_pkg::REG_DIAG, 32'h4);
    for (int i = 0; i < 256; i++)
    begin
      b = i[7:0];
      apb(1'b1, 12'h400 + {2'h0, b, 2'h0}, {8'h00, b, b, b});
    end
    apb(1'b1, pmd_pkg::REG_DIAG, 32'h5);
    p = link0_o;
    n = 0;
    while (link0_o === p && n < 50)
    begin
      @(negedge core_clk_i);
      n++;
    end
    repeat (5) @(negedge core_clk_i);
    for (int j = 0; j < 300; j++)
    begin
      p = link0_o;
      repeat (5) @(negedge core_clk_i);
      b = link0_o[7:0];
      chk(b === p[7:0] + 8'h01 && link0_o === {4'h0, b, b, b}, "driver word");
      chk(link1_o === link0_o, "driver copies");
    end
    apb(1'b1, pmd_pkg::REG_DIAG, 32'h0);
  endtask

  initial
  begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    l1_accept_i = 1'b0;
    l1_addr_i = 2'h0;
    run = 1'b0;
    skew = 1'b0;
    flt = 1'b0;
    split = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_merge();
    t_hold();
    t_l2();
    t_recv();
    t_drive();
    close_out();
  end
endmodule

// ### pmd_pkg.sv
// Shared types and constants of the pixel merge and duplication block
package pmd_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SLICE_PS = 33000;
  // Slice period rounded up to whole core cycles
  localparam int SLICE_CYCLES = (SLICE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Extra slices between finder logic and this block
  localparam logic [7:0] PIPE_COMP_SLICES = 8'h02;
  localparam int DIAG_WORDS = 256;
  localparam logic [8:0] CAP_SLICES = 9'h100;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int PADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_DIAG = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_L2_SEL = 12'h00C;
  localparam logic [11:0] REG_L2_DATA = 12'h010;
  localparam logic [1:0] RAM_WINDOW = 2'h1;
  localparam int CTRL_DEPTH_LSB = 0;
  localparam int CTRL_LINK_EN_LSB = 8;
  localparam int DIAG_CYCLE_BIT = 0;
  localparam int DIAG_MODE_LSB = 1;
  localparam int STAT_STATE_LSB = 12;
  localparam int STAT_DRV_ADDR_LSB = 16;
  localparam logic [7:0] DEPTH_RST = 8'h00;
  localparam logic [1:0] LINK_EN_RST = 2'h3;

  typedef enum logic [1:0] {
    PMD_MODE_NORMAL = 2'h0,
    PMD_MODE_RECEIVE = 2'h1,
    PMD_MODE_DRIVE = 2'h2
  } pmd_mode_type;

  // ****************************************************************
  // Data carriers
  // ****************************************************************
  typedef struct packed {
    logic [11:0] pix;
    logic beam0;
    logic word0;
    logic start_link;
    logic fault;
  } pmd_finder_type;

  typedef struct packed {
    logic fault;
    logic start_link;
    logic word0;
    logic beam0;
    logic [11:0] pix_b;
    logic [11:0] pix_a;
  } pmd_link_type;

  typedef struct packed {
    logic fault_b;
    logic fault_a;
    pmd_link_type merged;
  } pmd_slice_type;

endpackage
